// [rtl/wdp_datapath.sv]
// module: word datapath, arithmetic unit, flags and instruction pointer
// Summary of operation
// - memory is even-addressed words, two bytes each
// - memory sees 15-bit word address plus a low-byte flag
// - byte ops touch register high byte only
// - unit adds, subtracts, ands, ors, xors, complements
// - separate comparator drives flag bits 0-2
// - byte ops use upper half, low kept
// - pointer counts by two, bit zero zero
// - fetch at pointer, then pointer plus two
// - jumps load pointer with new target
// - pointer, flags, base visible outside, beside result and instruction word
// - base bit zero zero, register at base+2n
`timescale 1ns/1ps
module wdp_datapath
    import wdp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // sequencer requests
    input wire wdp_alu_req_s alu_req_i,
    input wire wdp_opnd_req_s opnd_req_i,
    input wire logic fetch_i,
    input wire logic ip_load_i,
    input wire logic [15:0] ip_target_i,
    input wire logic base_load_i,
    input wire logic [15:0] base_value_i,
    input wire logic flags_load_i,
    input wire logic [15:0] flags_value_i,
    // memory side
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_data_i,
    output logic mem_rd_o,
    output logic mem_fetch_o,
    output logic [14:0] mem_word_addr_o,
    output logic mem_low_byte_o,
    // results and visible registers
    output logic [15:0] instr_word_o,
    output logic [15:0] result_o,
    output logic result_valid_o,
    output logic [15:0] instruction_pointer_o,
    output logic [15:0] condition_flags_register_o,
    output logic [15:0] memory_register_block_o
);

    // ==========================================================
    // helper functions

    // one arithmetic step on 16 bits
    function automatic logic [15:0] alu_calc(input wdp_op_e op, input logic [15:0] s,
                                             input logic [15:0] d);
        logic [15:0] r;
        r = d;
        case (op)
            WDP_OP_ADD: r = d + s;
            WDP_OP_SUB: r = d - s;
            WDP_OP_AND: r = d & s;
            WDP_OP_OR: r = d | s;
            WDP_OP_XOR: r = d ^ s;
            WDP_OP_INV: r = ~s;
            default: r = d;
        endcase
        return r;
    endfunction : alu_calc

    // logical greater, arithmetic greater, equal of x against y
    function automatic logic [2:0] cmp_flags(input logic [15:0] x, input logic [15:0] y);
        logic [2:0] f;
        f[2] = x > y;
        f[1] = $signed(x) > $signed(y);
        f[0] = x == y;
        return f;
    endfunction : cmp_flags

    // ==========================================================
    // registers
    logic [15:0] ip_q, ip_d;
    logic [15:0] flags_q, flags_d;
    logic [15:0] base_q, base_d;
    logic [15:0] instr_q;
    logic [15:0] result_q;
    logic result_valid_q;
    logic mem_rd_q, mem_fetch_q, mem_low_q;
    logic [14:0] mem_addr_q;

    // ==========================================================
    // arithmetic unit and comparator

    // byte ops run in the upper half only; masking both operands keeps a carry or
    // borrow out of the low bytes from reaching the upper result
    wire logic [15:0] byte_mask = alu_req_i.byte_mode ? 16'hFF00 : 16'hFFFF;
    wire logic [15:0] alu_full = alu_calc(alu_req_i.op, alu_req_i.src & byte_mask,
                                          alu_req_i.dst & byte_mask);
    wire logic [15:0] alu_res = alu_req_i.byte_mode ? {alu_full[15:8], alu_req_i.dst[7:0]}
                                                    : alu_full;
    // masking the low byte lets the word comparator serve byte ops unchanged
    wire logic [15:0] cmp_mask = alu_req_i.byte_mode ? 16'hFF00 : 16'hFFFF;
    wire logic is_cmp = alu_req_i.op == WDP_OP_CMP;
    wire logic [15:0] cmp_x = (is_cmp ? alu_req_i.src : alu_res) & cmp_mask;
    wire logic [15:0] cmp_y = is_cmp ? (alu_req_i.dst & cmp_mask) : 16'h0000;
    wire logic [2:0] cmp_res = cmp_flags(cmp_x, cmp_y);

    // ==========================================================
    // next values of the program-visible registers

    // a full load (context restore) outranks a comparator update
    always_comb begin
        flags_d = flags_q;
        if (flags_load_i) begin
            flags_d = flags_value_i;
        end else if (alu_req_i.valid) begin
            flags_d[WDP_FLAG_LGT] = cmp_res[2];
            flags_d[WDP_FLAG_AGT] = cmp_res[1];
            flags_d[WDP_FLAG_EQ] = cmp_res[0];
        end
    end

    // a branch target outranks the step of a fetch in the same cycle
    always_comb begin
        ip_d = ip_q;
        if (ip_load_i) begin
            ip_d = {ip_target_i[15:1], 1'b0};
        end else if (fetch_i) begin
            ip_d = ip_q + WDP_IP_STEP;
        end
    end

    // base pointer keeps bit zero clear so registers stay word aligned
    assign base_d = base_load_i ? {base_value_i[15:1], 1'b0} : base_q;

    // ==========================================================
    // memory address selection

    // workspace register n sits at base + 2n
    wire logic [15:0] reg_addr = base_q + {11'h000, opnd_req_i.reg_num, 1'b0};
    wire logic [15:0] opnd_addr = opnd_req_i.use_reg ? reg_addr : opnd_req_i.byte_addr;
    // fetch wins over an operand access; the sequencer retries the operand
    wire logic [15:0] next_addr = fetch_i ? ip_q : opnd_addr;
    wire logic next_rd = fetch_i | opnd_req_i.valid;

    // ==========================================================
    // clocked state
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            ip_q <= WDP_IP_RST;
            flags_q <= WDP_FLAGS_RST;
            base_q <= WDP_BASE_RST;
        end else begin
            ip_q <= ip_d;
            flags_q <= flags_d;
            base_q <= base_d;
        end
    end

    // memory request stage: the word address and the low-byte flag leave the block
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            mem_rd_q <= 1'b0;
            mem_fetch_q <= 1'b0;
            mem_addr_q <= 15'h0000;
            mem_low_q <= 1'b0;
        end else begin
            mem_rd_q <= next_rd;
            mem_fetch_q <= fetch_i;
            mem_addr_q <= next_addr[15:1];
            mem_low_q <= next_addr[0] & ~fetch_i;
        end
    end

    // instruction word and arithmetic result capture
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            instr_q <= 16'h0000;
            result_q <= 16'h0000;
            result_valid_q <= 1'b0;
        end else begin
            if (instr_valid_i) begin
                instr_q <= instr_data_i;
            end
            if (alu_req_i.valid && !is_cmp) begin
                result_q <= alu_res;
            end
            result_valid_q <= alu_req_i.valid & ~is_cmp;
        end
    end

    // ==========================================================
    // outputs: the three visible registers, plus instruction word, result and memory request stage
    assign instruction_pointer_o = ip_q;
    assign condition_flags_register_o = flags_q;
    assign memory_register_block_o = base_q;
    assign instr_word_o = instr_q;
    assign result_o = result_q;
    assign result_valid_o = result_valid_q;
    assign mem_rd_o = mem_rd_q;
    assign mem_fetch_o = mem_fetch_q;
    assign mem_word_addr_o = mem_addr_q;
    assign mem_low_byte_o = mem_low_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence fetch_alone_s;
        fetch_i && !ip_load_i;
    endsequence

    ip_even_a: assert property (ip_q[0] == 1'b0 && base_q[0] == 1'b0)
        else $error("pointer or base bit zero set");
    ip_step_a: assert property (fetch_alone_s |=> ip_q == $past(ip_q) + 16'h0002)
        else $error("pointer did not step by two");
    fetch_addr_a: assert property (fetch_alone_s |=> mem_rd_o && mem_fetch_o &&
                                   mem_word_addr_o == $past(ip_q[15:1]))
        else $error("fetch address not pointer word");
    ip_branch_a: assert property (ip_load_i |=> ip_q == {$past(ip_target_i[15:1]), 1'b0})
        else $error("branch target not loaded");
    byte_low_a: assert property (alu_req_i.valid && alu_req_i.byte_mode && !is_cmp
                                 |=> result_o[7:0] == $past(alu_req_i.dst[7:0]))
        else $error("byte op changed low byte");
    add_word_a: assert property (alu_req_i.valid && !alu_req_i.byte_mode &&
                                 alu_req_i.op == WDP_OP_ADD
                                 |=> result_o == $past(alu_req_i.dst) + $past(alu_req_i.src))
        else $error("word add wrong");
    flag_eq_a: assert property (alu_req_i.valid && !flags_load_i && !alu_req_i.byte_mode
                                && !is_cmp |=> flags_q[WDP_FLAG_EQ] == (result_o == 16'h0000))
        else $error("equal flag does not match result");
    byte_flag_a: assert property (alu_req_i.valid && !flags_load_i && alu_req_i.byte_mode
                                  && !is_cmp
                                  |=> flags_q[WDP_FLAG_EQ] == (result_o[15:8] == 8'h00))
        else $error("byte equal flag not from high byte");
    reg_addr_a: assert property (opnd_req_i.valid && opnd_req_i.use_reg && !fetch_i
                                 |=> mem_word_addr_o == $past(base_q[15:1]) +
                                     {11'h000, $past(opnd_req_i.reg_num)})
        else $error("register address not base plus 2n");
    flags_hold_a: assert property (!alu_req_i.valid && !flags_load_i |=> $stable(flags_q))
        else $error("flags changed without cause");

endmodule : wdp_datapath

// [rtl/wdp_pkg.sv]
// package: shared types and constants for the word datapath
package wdp_pkg;

    // ==========================================================
    // widths and reset values
    localparam int WDP_DW = 16;
    localparam logic [15:0] WDP_IP_RST = 16'h0000;
    localparam logic [15:0] WDP_FLAGS_RST = 16'h0000;
    localparam logic [15:0] WDP_BASE_RST = 16'h0000;
    localparam logic [15:0] WDP_IP_STEP = 16'h0002;

    // ==========================================================
    // condition flag positions (flag 0 is the most significant bit)
    localparam int WDP_FLAG_LGT = 15;
    localparam int WDP_FLAG_AGT = 14;
    localparam int WDP_FLAG_EQ = 13;

    // ==========================================================
    // operations of the arithmetic unit
    typedef enum logic [2:0] {
        WDP_OP_ADD = 3'b000,
        WDP_OP_SUB = 3'b001,
        WDP_OP_AND = 3'b010,
        WDP_OP_OR = 3'b011,
        WDP_OP_XOR = 3'b100,
        WDP_OP_INV = 3'b101,
        WDP_OP_CMP = 3'b110
    } wdp_op_e;

    // one arithmetic step from the sequencer
    typedef struct packed {
        logic valid;
        wdp_op_e op;
        logic byte_mode;
        logic [15:0] src;
        logic [15:0] dst;
    } wdp_alu_req_s;

    // one operand memory access from the sequencer
    typedef struct packed {
        logic valid;
        logic use_reg;
        logic [3:0] reg_num;
        logic [15:0] byte_addr;
    } wdp_opnd_req_s;

endpackage : wdp_pkg

// [verif/wdp_mem_model.sv]
// memory model: answers instruction fetches by word address
`timescale 1ns/1ps
module wdp_mem_model (
    // clock and pacing
    input wire logic sys_clk_i,
    input wire logic slow_i,
    // datapath memory side
    input wire logic mem_rd_i,
    input wire logic mem_fetch_i,
    input wire logic [14:0] mem_word_addr_i,
    output logic instr_valid_o,
    output logic [15:0] instr_data_o
);
    logic pend_q = 1'b0;
    logic [1:0] dly_q = 2'h0;
    logic [14:0] addr_q = 15'h0000;
    logic [15:0] last_q = 16'h0000;
    // word content echoes its word address, so a wrong address shows up
    assign instr_valid_o = pend_q && dly_q == 2'h0;
    assign instr_data_o = instr_valid_o ? {1'b1, addr_q} : ~last_q;
    // one pending fetch; slow mode stalls three cycles, idle bus shows junk
    always @(posedge sys_clk_i) begin
        if (mem_rd_i && mem_fetch_i) begin
            pend_q <= 1'b1;
            addr_q <= mem_word_addr_i;
            dly_q <= slow_i ? 2'h3 : 2'h0;
        end else if (instr_valid_o) begin
            pend_q <= 1'b0;
            last_q <= instr_data_o;
        end else if (pend_q) begin
            dly_q <= dly_q - 2'h1;
        end
    end
endmodule : wdp_mem_model

// [verif/tb_word_datapath_and_program_counter.sv]
// testbench: directed scenarios for the word datapath
`timescale 1ns/1ps
module tb_word_datapath_and_program_counter
    import wdp_pkg::*;
;
    // ==========================================================
    // stimulus and observed signals
    logic clk = 1'b0, rst_b = 1'b0, slow = 1'b0;
    logic fetch = 1'b0, ipl = 1'b0, bsl = 1'b0, fll = 1'b0;
    logic [15:0] ipt = 16'h0000, bsv = 16'h0000, flv = 16'h0000;
    wdp_alu_req_s areq = '0;
    wdp_opnd_req_s oreq = '0;
    logic iv, rd, mf, lb, rv;
    logic [14:0] wa;
    logic [15:0] idat, iw, res, ip, fl, base;
    int errors = 0, comparisons = 0;
    always #25 clk = ~clk;
    wdp_datapath u_wdp_datapath (.sys_clk_i(clk), .rst_b_i(rst_b), .alu_req_i(areq),
        .opnd_req_i(oreq), .fetch_i(fetch), .ip_load_i(ipl), .ip_target_i(ipt),
        .base_load_i(bsl), .base_value_i(bsv), .flags_load_i(fll), .flags_value_i(flv),
        .instr_valid_i(iv), .instr_data_i(idat), .mem_rd_o(rd), .mem_fetch_o(mf),
        .mem_word_addr_o(wa), .mem_low_byte_o(lb), .instr_word_o(iw), .result_o(res),
        .result_valid_o(rv), .instruction_pointer_o(ip),
        .condition_flags_register_o(fl), .memory_register_block_o(base));
    wdp_mem_model u_wdp_mem_model (.sys_clk_i(clk), .slow_i(slow), .mem_rd_i(rd),
        .mem_fetch_i(mf), .mem_word_addr_i(wa), .instr_valid_o(iv), .instr_data_o(idat));
    // ==========================================================
    // shared helpers
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    function automatic logic [15:0] calc(input wdp_op_e op, input logic [15:0] s, d);
        case (op)
            WDP_OP_ADD: calc = d + s;
            WDP_OP_SUB: calc = d - s;
            WDP_OP_AND: calc = d & s;
            WDP_OP_OR: calc = d | s;
            WDP_OP_XOR: calc = d ^ s;
            WDP_OP_INV: calc = ~s;
            default: calc = d;
        endcase
    endfunction : calc
    // ==========================================================
    // scenarios
    task automatic do_fetch(input logic sl);
        logic [15:0] p;
        int n;
        p = ip;
        @(posedge clk);
        slow <= sl;
        fetch <= 1'b1;
        @(posedge clk);
        fetch <= 1'b0;
        #1;
        chk("ip", p + WDP_IP_STEP, ip);
        chk("waddr", {1'b0, p[15:1]}, {1'b0, wa});
        chk("fetch", 16'h0003, {14'h0000, rd, mf});
        n = 0;
        while (iv !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (iv !== 1'b1) begin
            errors++;
            conclude();
        end
        @(posedge clk);
        #1;
        chk("instr", {1'b1, p[15:1]}, iw);
        $display("done fetch slow=%0d", sl);
    endtask : do_fetch
    task automatic alu(input wdp_op_e op, input logic bm, input logic [15:0] s, d);
        logic [15:0] r, v, sm, dm, old;
        logic [2:0] f;
        old = res;
        sm = bm ? {s[15:8], 8'h00} : s;
        dm = bm ? {d[15:8], 8'h00} : d;
        r = calc(op, sm, dm);
        v = bm ? {r[15:8], 8'h00} : r;
        if (bm) r = {r[15:8], d[7:0]};
        if (op == WDP_OP_CMP) f = {sm > dm, $signed(sm) > $signed(dm), sm == dm};
        else f = {v != 16'h0000, $signed(v) > $signed(16'h0000), v == 16'h0000};
        @(posedge clk);
        areq <= '{1'b1, op, bm, s, d};
        @(posedge clk);
        areq.valid <= 1'b0;
        #1;
        chk("result", op == WDP_OP_CMP ? old : r, res);
        chk("rvalid", {15'h0000, op != WDP_OP_CMP}, {15'h0000, rv});
        chk("flags", {13'h0000, f},
            {13'h0000, fl[WDP_FLAG_LGT], fl[WDP_FLAG_AGT], fl[WDP_FLAG_EQ]});
    endtask : alu
    task automatic regs_and_operands();
        @(posedge clk);
        ipl <= 1'b1;
        ipt <= 16'h1235;
        fetch <= 1'b1;
        bsl <= 1'b1;
        bsv <= 16'h0101;
        fll <= 1'b1;
        flv <= 16'h5A5A;
        areq <= '{1'b1, WDP_OP_ADD, 1'b0, 16'h0001, 16'h0001};
        @(posedge clk);
        {ipl, fetch, bsl, fll} <= 4'h0;
        areq.valid <= 1'b0;
        oreq <= '{1'b1, 1'b1, 4'hF, 16'h0000};
        #1;
        chk("iptgt", 16'h1234, ip);
        chk("base", 16'h0100, base);
        chk("flload", 16'h5A5A, fl);
        @(posedge clk);
        oreq <= '{1'b1, 1'b0, 4'h0, 16'h2345};
        #1;
        chk("regaddr", 16'h008F, {1'b0, wa});
        chk("regrd", 16'h0002, {14'h0000, rd, mf | lb});
        @(posedge clk);
        oreq.valid <= 1'b0;
        #1;
        chk("byteaddr", 16'h11A2, {1'b0, wa});
        chk("lowbyte", 16'h0003, {14'h0000, rd, lb});
        $display("done registers and operands");
    endtask : regs_and_operands
    // reset in mid-run must bring every visible register back to its reset value
    task automatic mid_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("mr_ip", WDP_IP_RST, ip);
        chk("mr_fl", WDP_FLAGS_RST, fl);
        chk("mr_base", WDP_BASE_RST, base);
        chk("mr_res", 16'h0000, res);
        chk("mr_instr", 16'h0000, iw);
        chk("mr_strobes", 16'h0000, {13'h0000, rd, mf, rv});
        $display("done mid-run reset");
    endtask : mid_reset
    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("rst_ip", WDP_IP_RST, ip);
        chk("rst_fl", WDP_FLAGS_RST, fl);
        chk("rst_base", WDP_BASE_RST, base);
        $display("done reset");
        regs_and_operands();
        do_fetch(1'b0);
        do_fetch(1'b1);
        for (int i = 0; i < 7; i++) begin
            alu(wdp_op_e'(i), 1'b0, 16'h8001, 16'h7FFF);
            alu(wdp_op_e'(i), 1'b1, 16'h0F12, 16'hF034);
        end
        mid_reset();
        // low bytes that carry or borrow must not disturb the upper byte; then a word subtract to zero, then a byte compare whose low bytes differ
        alu(WDP_OP_ADD, 1'b1, 16'h0180, 16'h0280);
        alu(WDP_OP_SUB, 1'b1, 16'h0190, 16'h0280);
        alu(WDP_OP_SUB, 1'b0, 16'h1234, 16'h1234);
        alu(WDP_OP_CMP, 1'b1, 16'h12FF, 16'h1200);
        $display("done arithmetic");
        conclude();
    end
endmodule : tb_word_datapath_and_program_counter
